// ===== verilog/cca_top.sv
// Counter array top: APB registers, shared time base and five modules
`timescale 1ns/1ps
`include "cca_defs.svh"
module cca_top #(
    parameter int NUM_MOD = `CCA_NUM_MODULES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor state and timer 0
    input wire logic cpuIdle,
    input wire logic timer0Overflow,
    // External count pin
    input wire logic externalCountPin,
    // Module pins and standard port fallback
    input wire logic [NUM_MOD-1:0] moduleIoIn,
    input wire logic [NUM_MOD-1:0] portDataOut,
    input wire logic [NUM_MOD-1:0] portDriveEn,
    output logic [NUM_MOD-1:0] moduleIoOut,
    output logic [NUM_MOD-1:0] moduleIoOe,
    // Requests to the core
    output logic irqReq,
    output logic wdResetReq
);
    // ****************************************
    // Declarations
    // ****************************************
    logic idleStop_reg; // Halt in idle
    logic moduleWatchdogEn_reg; // Module 4 watchdog
    cca_pkg::cca_src_t srcSel_reg; // Count source
    logic overflowIrqEn_reg;
    logic overflowFlag_reg;
    logic runCtl_reg;
    logic [NUM_MOD-1:0] moduleFlags_reg;
    logic [15:0] count_reg; // Time base
    logic countStep_reg; // Count just stepped by a tick
    logic [2:0] presc_reg; // Clock divider
    cca_pkg::cca_mode_t moduleMode_reg [NUM_MOD];
    logic [15:0] capVal [NUM_MOD];
    logic [NUM_MOD-1:0] flagEv;
    logic [NUM_MOD-1:0] matchHit;
    logic [NUM_MOD-1:0] pinLevel;
    logic [NUM_MOD-1:0] pinDrive;
    logic [NUM_MOD-1:0] flagIrqEn; // Per-module flag interrupt enables
    logic [NUM_MOD-1:0] capRise;
    logic [NUM_MOD-1:0] capFall;
    logic extRise;
    logic running;
    logic tick;
    logic apbWr;
    logic apbSetup;
    logic [5:0] wordIdx;
    logic [31:0] rdData;
    logic rdHit;

    // ****************************************
    // Input synchronisers
    // ****************************************
    // External count pin
    cca_sync u_count_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinIn(externalCountPin),
        .level(),
        .rise(extRise),
        .fall()
    );

    // Module pins and module instances
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
            cca_sync u_sync (
                .mclk(mclk),
                .rst_n(rst_n),
                .pinIn(moduleIoIn[gi]),
                .level(),
                .rise(capRise[gi]),
                .fall(capFall[gi])
            );
            cca_channel u_chan (
                .mclk(mclk),
                .rst_n(rst_n),
                .mode(moduleMode_reg[gi]),
                .count(count_reg),
                .countStep(countStep_reg),
                .capRise(capRise[gi]),
                .capFall(capFall[gi]),
                .wrEn(apbWr && wordIdx == 6'(`CCA_OFS_CAP0 / 4 + gi)),
                .wrData(pwdata[15:0]),
                .capVal(capVal[gi]),
                .flagEvent(flagEv[gi]),
                .matchHit(matchHit[gi]),
                .pinLevel(pinLevel[gi]),
                .pinDrive(pinDrive[gi])
            );
            // Mode byte per module
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    moduleMode_reg[gi] <= `CCA_RST_BYTE;
                end else if (apbWr && wordIdx == 6'(`CCA_OFS_MMODE0 / 4 + gi)) begin
                    moduleMode_reg[gi] <= pwdata[7:0];
                end
            end
            assign flagIrqEn[gi] = moduleMode_reg[gi].moduleFlagIrqEn;
            // Pin owned by the module, else standard port
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    moduleIoOut[gi] <= 1'b0;
                    moduleIoOe[gi] <= 1'b0;
                end else begin
                    moduleIoOut[gi] <= pinDrive[gi] ? pinLevel[gi] : portDataOut[gi];
                    moduleIoOe[gi] <= pinDrive[gi] || portDriveEn[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // APB decode
    // ****************************************
    assign apbSetup = psel && !penable;
    assign apbWr = psel && penable && pwrite && pready;
    assign wordIdx = paddr[7:2];

    // Read mux; unmapped words read zero and flag an error
    always_comb begin
        rdData = 32'h0000_0000;
        rdHit = 1'b1;
        if (wordIdx == 6'(`CCA_OFS_MODE / 4)) begin
            rdData[7:0] = {idleStop_reg, moduleWatchdogEn_reg, 3'h0, srcSel_reg,
                overflowIrqEn_reg};
        end else if (wordIdx == 6'(`CCA_OFS_CTRL / 4)) begin
            rdData[7:0] = {overflowFlag_reg, runCtl_reg, 1'b0, moduleFlags_reg};
        end else if (wordIdx == 6'(`CCA_OFS_COUNT / 4)) begin
            rdData[15:0] = count_reg;
        end else if (wordIdx >= 6'(`CCA_OFS_MMODE0 / 4)
            && wordIdx < 6'(`CCA_OFS_MMODE0 / 4 + NUM_MOD)) begin
            rdData[7:0] = moduleMode_reg[3'(wordIdx - 6'(`CCA_OFS_MMODE0 / 4))];
        end else if (wordIdx >= 6'(`CCA_OFS_CAP0 / 4)
            && wordIdx < 6'(`CCA_OFS_CAP0 / 4 + NUM_MOD)) begin
            rdData[15:0] = capVal[3'(wordIdx - 6'(`CCA_OFS_CAP0 / 4))];
        end else begin
            rdHit = 1'b0;
        end
    end

    // Answer in the first access cycle; data taken at setup
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apbSetup;
            pslverr <= apbSetup && !rdHit;
            if (apbSetup) begin
                prdata <= pwrite ? 32'h0000_0000 : rdData;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    // Array mode register fields
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idleStop_reg <= 1'b0;
            moduleWatchdogEn_reg <= 1'b0;
            srcSel_reg <= cca_pkg::SRC_DIV6;
            overflowIrqEn_reg <= 1'b0;
        end else if (apbWr && wordIdx == 6'(`CCA_OFS_MODE / 4)) begin
            idleStop_reg <= pwdata[`CCA_MODE_IDLE_BIT];
            moduleWatchdogEn_reg <= pwdata[`CCA_MODE_WDEN_BIT];
            srcSel_reg <= cca_pkg::cca_src_t'(pwdata[`CCA_MODE_SRC_LSB +: 2]);
            overflowIrqEn_reg <= pwdata[`CCA_MODE_OVIE_BIT];
        end
    end

    // Run bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            runCtl_reg <= 1'b0;
        end else if (apbWr && wordIdx == 6'(`CCA_OFS_CTRL / 4)) begin
            runCtl_reg <= pwdata[`CCA_CTRL_RUN_BIT];
        end
    end

    // Flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            overflowFlag_reg <= 1'b0;
            moduleFlags_reg <= '0;
        end else begin
            if (apbWr && wordIdx == 6'(`CCA_OFS_CTRL / 4)) begin
                overflowFlag_reg <= pwdata[`CCA_CTRL_OVF_BIT] || (tick && &count_reg);
                moduleFlags_reg <= pwdata[NUM_MOD-1:0] | flagEv;
            end else begin
                overflowFlag_reg <= overflowFlag_reg || (tick && &count_reg);
                moduleFlags_reg <= moduleFlags_reg | flagEv;
            end
        end
    end

    // ****************************************
    // Time base
    // ****************************************
    // Stopped by run bit or by idle with idle-stop set
    assign running = runCtl_reg && !(idleStop_reg && cpuIdle);

    // Free divider, only advances while running
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= 3'h0;
        end else if (running) begin
            presc_reg <= (presc_reg == `CCA_DIV_SLOW) ? 3'h0 : presc_reg + 3'h1;
        end
    end

    // Count pulse source; pin pulses above a quarter clock rate are lost
    always_comb begin
        case (srcSel_reg)
            cca_pkg::SRC_DIV6: tick = running && presc_reg == `CCA_DIV_SLOW;
            cca_pkg::SRC_DIV2: tick = running && presc_reg[0];
            cca_pkg::SRC_TIMER0: tick = running && timer0Overflow;
            cca_pkg::SRC_PIN: tick = running && extRise;
            default: tick = 1'b0;
        endcase
    end

    // Counter: software write wins over a tick
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= `CCA_RST_WORD;
            countStep_reg <= 1'b0;
        end else if (apbWr && wordIdx == 6'(`CCA_OFS_COUNT / 4)) begin
            count_reg <= pwdata[15:0];
            countStep_reg <= 1'b0;
        end else begin
            count_reg <= tick ? count_reg + 16'h0001 : count_reg;
            countStep_reg <= tick;
        end
    end

    // ****************************************
    // Requests
    // ****************************************
    // Merged interrupt and module 4 watchdog reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irqReq <= 1'b0;
            wdResetReq <= 1'b0;
        end else begin
            irqReq <= (overflowFlag_reg && overflowIrqEn_reg)
                || |(moduleFlags_reg & flagIrqEn);
            wdResetReq <= moduleWatchdogEn_reg && matchHit[`CCA_WDOG_MODULE];
        end
    end
endmodule : cca_top

// ===== verilog/cca_defs.svh
// Register offsets, field positions, reset values and timing counts of the counter array
`ifndef CCA_DEFS_SVH
`define CCA_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CCA_OFS_MODE 8'h00
`define CCA_OFS_CTRL 8'h04
`define CCA_OFS_COUNT 8'h08
`define CCA_OFS_MMODE0 8'h10
`define CCA_OFS_CAP0 8'h30

// ****************************************
// Field positions
// ****************************************
`define CCA_MODE_IDLE_BIT 7
`define CCA_MODE_WDEN_BIT 6
`define CCA_MODE_SRC_LSB 1
`define CCA_MODE_OVIE_BIT 0
`define CCA_CTRL_OVF_BIT 7
`define CCA_CTRL_RUN_BIT 6

// ****************************************
// Reset values and counts
// ****************************************
`define CCA_RST_BYTE 8'h00
`define CCA_RST_WORD 16'h0000
`define CCA_DIV_SLOW 3'h5
`define CCA_NUM_MODULES 5
`define CCA_WDOG_MODULE 4

`endif

// ===== verilog/cca_pkg.sv
// Types shared by the counter array files
package cca_pkg;

    // Count pulse source of the time base
    typedef enum logic [1:0] {
        SRC_DIV6 = 2'b00,
        SRC_DIV2 = 2'b01,
        SRC_TIMER0 = 2'b10,
        SRC_PIN = 2'b11
    } cca_src_t;

    // One module mode byte, msb first
    typedef struct packed {
        logic spare;
        logic comparatorEn;
        logic captureRising;
        logic captureFalling;
        logic flagOnMatch;
        logic toggleOnMatch;
        logic pwmEn;
        logic moduleFlagIrqEn;
    } cca_mode_t;

endpackage : cca_pkg

// ===== verilog/cca_sync.sv
// Three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module cca_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Asynchronous pin
    input wire logic pinIn,
    // Clean level and edge pulses
    output logic level,
    output logic rise,
    output logic fall
);
    logic stage1_reg; // Read by stage2 only
    logic stage2_reg;
    logic stage3_reg;

    // ****************************************
    // Synchroniser chain
    // ****************************************
    // Shift the pin through three flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Accept a change only once stages two and three agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= (stage2_reg == stage3_reg) && stage3_reg && !level;
            fall <= (stage2_reg == stage3_reg) && !stage3_reg && level;
            if (stage2_reg == stage3_reg) begin
                level <= stage3_reg;
            end
        end
    end
endmodule : cca_sync

// ===== verilog/cca_channel.sv
// One compare/capture module of the counter array
`timescale 1ns/1ps
`include "cca_defs.svh"
module cca_channel (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Mode and time base
    input wire cca_pkg::cca_mode_t mode,
    input wire logic [15:0] count,
    input wire logic countStep,
    // Synchronised pin edges
    input wire logic capRise,
    input wire logic capFall,
    // Software write of the capture/compare word
    input wire logic wrEn,
    input wire logic [15:0] wrData,
    // Results
    output logic [15:0] capVal,
    output logic flagEvent,
    output logic matchHit,
    output logic pinLevel,
    output logic pinDrive
);
    logic [7:0] duty_reg; // Active PWM duty byte
    logic capEv;
    logic matchEv;

    // Armed edge detection
    assign capEv = (capRise && mode.captureRising) || (capFall && mode.captureFalling);
    // Compare only on a fresh counter value, so one match per value
    assign matchEv = mode.comparatorEn && countStep && (count == capVal);
    assign pinDrive = mode.pwmEn || mode.toggleOnMatch;
    assign matchHit = matchEv;

    // ****************************************
    // Capture/compare word
    // ****************************************
    // Software write wins over a capture in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            capVal <= `CCA_RST_WORD;
        end else if (wrEn) begin
            capVal <= wrData;
        end else if (capEv) begin
            capVal <= count;
        end
    end

    // Flag event pulse: capture or flagged match
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flagEvent <= 1'b0;
        end else begin
            flagEvent <= capEv || (matchEv && mode.flagOnMatch);
        end
    end

    // ****************************************
    // Output waveform
    // ****************************************
    // Duty reloads only at low byte wrap, so updates are glitch free
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            duty_reg <= `CCA_RST_BYTE;
        end else if (countStep && count[7:0] == 8'h00) begin
            duty_reg <= capVal[15:8];
        end
    end

    // PWM level, or toggle on each match
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinLevel <= 1'b0;
        end else if (mode.pwmEn) begin
            pinLevel <= (count[7:0] >= duty_reg);
        end else if (matchEv && mode.toggleOnMatch) begin
            pinLevel <= !pinLevel;
        end
    end
endmodule : cca_channel

// ===== tb/cca_top_props.sv
// Port-level checker of the counter array, bound into the top module
`timescale 1ns/1ps
module cca_top_props #(
    parameter int NUM_MOD = 5
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Requests and pins
    input wire logic [NUM_MOD-1:0] moduleIoOe,
    input wire logic irqReq,
    input wire logic wdResetReq
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Zero wait states: answer in the first access cycle
    property p_setupAnswer;
        psel && !penable |=> pready;
    endproperty
    a_setupAnswer: assert property (p_setupAnswer) else $error("pready missing after setup");
    // Ready is a single-cycle pulse
    property p_readyPulse;
        pready |=> !pready;
    endproperty
    a_readyPulse: assert property (p_readyPulse) else $error("pready longer than one cycle");
    // Ready only inside an access phase
    property p_readyInAccess;
        pready |-> psel && penable;
    endproperty
    a_readyInAccess: assert property (p_readyInAccess) else $error("pready outside access");
    // Error only together with ready
    property p_errWithReady;
        pslverr |-> pready;
    endproperty
    a_errWithReady: assert property (p_errWithReady) else $error("pslverr without pready");
    // Refused reads return zero
    property p_errReadZero;
        pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    a_errReadZero: assert property (p_errReadZero) else $error("refused read not zero");
    // Outputs quiet at the first edge after reset
    property p_quietAfterReset;
        $rose(rst_n) |-> !irqReq && !wdResetReq && moduleIoOe == '0;
    endproperty
    a_quietAfterReset: assert property (p_quietAfterReset) else $error("outputs active at reset");
    // Internal reset request is one cycle long
    property p_wdPulse;
        wdResetReq |=> !wdResetReq;
    endproperty
    a_wdPulse: assert property (p_wdPulse) else $error("reset request too long");
    // Request drops only after a software write
    property p_irqDropOnWrite;
        $fell(irqReq) |-> $past(pwrite && penable, 1) || $past(pwrite && penable, 2);
    endproperty
    a_irqDropOnWrite: assert property (p_irqDropOnWrite) else $error("irq fell by itself");

    // ****************************************
    // Coverage of main scenarios
    // ****************************************
    c_irq: cover property ($rose(irqReq));
    c_wd: cover property (wdResetReq);
    c_err: cover property (pslverr);
    c_drive: cover property (moduleIoOe != '0);
endmodule : cca_top_props

bind cca_top cca_top_props #(.NUM_MOD(NUM_MOD)) i_cca_top_props (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .moduleIoOe(moduleIoOe), .irqReq(irqReq), .wdResetReq(wdResetReq));

// ===== tb/cca_pin_model.sv
// Far-side model of the module pins and the external count pin
`timescale 1ns/1ps
module cca_pin_model #(
    parameter int NUM_MOD = 5
) (
    // Clock
    input wire logic mclk,
    // Commanded far-side levels
    input wire logic [NUM_MOD-1:0] levelCmd,
    input wire logic extRun,
    // Drive from the device
    input wire logic [NUM_MOD-1:0] moduleIoOut,
    input wire logic [NUM_MOD-1:0] moduleIoOe,
    // Levels seen by the device, and the rise count of the count pin
    output logic [NUM_MOD-1:0] moduleIoIn,
    output logic externalCountPin,
    output logic [15:0] nRise
);
    logic [1:0] phase; // Toggle spacing counter
    // Wire level: device drive wins where enabled
    assign moduleIoIn = (moduleIoOe & moduleIoOut) | (~moduleIoOe & levelCmd);
    // Idle low through a pull-down
    initial begin
        externalCountPin = 1'b0;
        nRise = 16'h0;
        phase = 2'h0;
    end
    // Toggle every 4 clocks, mclk/8, safely below the pin rate limit
    always @(posedge mclk) begin
        if (extRun) begin
            phase <= phase + 2'h1;
            if (phase == 2'h3) begin
                externalCountPin <= ~externalCountPin;
                if (!externalCountPin) begin
                    nRise <= nRise + 16'h1;
                end
            end
        end else begin
            phase <= 2'h0;
            externalCountPin <= 1'b0;
        end
    end
endmodule : cca_pin_model

// ===== tb/cca_top_tb_top.sv
// Self-checking testbench of the counter array
`timescale 1ns/1ps
`include "cca_defs.svh"
module cca_top_tb_top;
    // ****************************************
    // Signals
    // ****************************************
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, lastErr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, q2;
    logic cpuIdle, timer0Overflow, externalCountPin, irqReq, wdResetReq, extRun;
    logic [4:0] moduleIoIn, portDataOut, portDriveEn, moduleIoOut, moduleIoOe, levelCmd;
    logic [15:0] nRise, n0;
    int nErrors, numChecks, wdCount;

    // Device and far-side model
    cca_top i_cca_top (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpuIdle(cpuIdle), .timer0Overflow(timer0Overflow),
        .externalCountPin(externalCountPin), .moduleIoIn(moduleIoIn),
        .portDataOut(portDataOut), .portDriveEn(portDriveEn), .moduleIoOut(moduleIoOut),
        .moduleIoOe(moduleIoOe), .irqReq(irqReq), .wdResetReq(wdResetReq));
    cca_pin_model i_cca_pin_model (.mclk(mclk), .levelCmd(levelCmd), .extRun(extRun),
        .moduleIoOut(moduleIoOut), .moduleIoOe(moduleIoOe), .moduleIoIn(moduleIoIn),
        .externalCountPin(externalCountPin), .nRise(nRise));

    // ****************************************
    // Helpers
    // ****************************************
    // Clock, 50 ns period
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Internal reset request counter
    always @(posedge mclk) begin
        if (wdResetReq === 1'b1) wdCount <= wdCount + 1;
    end
    // One APB transfer; waits for pready, only the hang guard ends a stuck wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [7:0] modeAdr(input int n);
        return `CCA_OFS_MMODE0 + 8'(4 * n);
    endfunction : modeAdr
    function automatic logic [7:0] capAdr(input int n);
        return `CCA_OFS_CAP0 + 8'(4 * n);
    endfunction : capAdr
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One timer 0 overflow pulse, then settle
    task automatic pulse();
        @(posedge mclk);
        timer0Overflow <= 1'b1;
        @(posedge mclk);
        timer0Overflow <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : pulse
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    // ****************************************
    // Scenarios
    // ****************************************
    // Reset values, refused address, port fallback
    task automatic t_reset();
        apb(0, `CCA_OFS_MODE, 0);
        check(q, 32'h0);
        apb(0, `CCA_OFS_COUNT, 0);
        check(q, 32'h0);
        apb(0, 8'hFC, 0);
        check({q[31:1], lastErr}, 32'h1);
        portDataOut <= 5'h0A;
        portDriveEn <= 5'h1F;
        repeat (3) @(posedge mclk);
        check({moduleIoOe, moduleIoOut}, 32'h3EA);
        portDriveEn <= 5'h00;
    endtask : t_reset
    // Divided clocks and the count pin
    task automatic t_sources();
        for (int s = 0; s < 2; s++) begin
            apb(1, `CCA_OFS_CTRL, 0);
            apb(1, `CCA_OFS_COUNT, 0);
            apb(1, `CCA_OFS_MODE, 32'(s * 2));
            apb(1, `CCA_OFS_CTRL, 32'h40);
            repeat (60) @(posedge mclk);
            apb(0, `CCA_OFS_COUNT, 0);
            check(32'(q >= (s ? 29 : 9) && q <= (s ? 33 : 12)), 32'h1);
        end
        apb(1, `CCA_OFS_MODE, 32'h6);
        apb(1, `CCA_OFS_COUNT, 0);
        n0 = nRise;
        extRun <= 1'b1;
        repeat (80) @(posedge mclk);
        extRun <= 1'b0;
        repeat (10) @(posedge mclk);
        apb(0, `CCA_OFS_COUNT, 0);
        check(q, 32'(nRise - n0));
    endtask : t_sources
    // Rollover, sticky flag, run stop, request gating
    task automatic t_overflow();
        apb(1, `CCA_OFS_CTRL, 0);
        apb(1, `CCA_OFS_COUNT, 32'hFFFE);
        apb(1, `CCA_OFS_MODE, 32'h3);
        apb(1, `CCA_OFS_CTRL, 32'h40);
        repeat (20) @(posedge mclk);
        apb(1, `CCA_OFS_CTRL, 32'h80);
        check(irqReq, 1'b1);
        apb(0, `CCA_OFS_COUNT, 0);
        q2 = q;
        check(32'(q >= 2 && q <= 16), 32'h1);
        repeat (20) @(posedge mclk);
        apb(0, `CCA_OFS_COUNT, 0);
        check(q, q2);
        apb(0, `CCA_OFS_CTRL, 0);
        check(q, 32'h80);
        apb(1, `CCA_OFS_MODE, 32'h2);
        repeat (3) @(posedge mclk);
        check(irqReq, 1'b0);
        apb(1, `CCA_OFS_MODE, 32'h3);
        apb(1, `CCA_OFS_CTRL, 0);
        repeat (3) @(posedge mclk);
        check(irqReq, 1'b0);
    endtask : t_overflow
    // Idle stop
    task automatic t_idle();
        apb(1, `CCA_OFS_COUNT, 0);
        apb(1, `CCA_OFS_MODE, 32'h82);
        cpuIdle <= 1'b1;
        apb(1, `CCA_OFS_CTRL, 32'h40);
        repeat (30) @(posedge mclk);
        apb(0, `CCA_OFS_COUNT, 0);
        check(q, 32'h0);
        apb(1, `CCA_OFS_MODE, 32'h2);
        repeat (30) @(posedge mclk);
        apb(0, `CCA_OFS_COUNT, 0);
        check(32'(q >= 10 && q <= 20), 32'h1);
        cpuIdle <= 1'b0;
        apb(1, `CCA_OFS_CTRL, 0);
    endtask : t_idle
    // Rising, falling and both-edge capture
    task automatic t_capture();
        apb(1, `CCA_OFS_COUNT, 32'h1234);
        apb(1, modeAdr(0), 32'h21);
        apb(1, modeAdr(1), 32'h10);
        apb(1, modeAdr(2), 32'h30);
        levelCmd <= 5'h07;
        repeat (10) @(posedge mclk);
        apb(0, capAdr(1), 0);
        check(q, 32'h0);
        apb(1, `CCA_OFS_COUNT, 32'h5678);
        levelCmd <= 5'h00;
        repeat (10) @(posedge mclk);
        for (int i = 0; i < 3; i++) begin
            apb(0, capAdr(i), 0);
            check(q, i ? 32'h5678 : 32'h1234);
        end
        apb(0, `CCA_OFS_CTRL, 0);
        check(q, 32'h07);
        check(irqReq, 1'b1);
        apb(1, `CCA_OFS_CTRL, 0);
    endtask : t_capture
    // Compare match, toggle output, disabled comparator
    task automatic t_match();
        apb(1, modeAdr(2), 32'h4C);
        apb(1, modeAdr(3), 32'h08);
        apb(1, capAdr(2), 32'h12);
        apb(1, capAdr(3), 32'h12);
        apb(1, modeAdr(4), 32'h40);
        apb(1, capAdr(4), 32'h14);
        apb(1, `CCA_OFS_COUNT, 32'h10);
        apb(1, `CCA_OFS_MODE, 32'h4);
        apb(1, `CCA_OFS_CTRL, 32'h40);
        pulse();
        pulse();
        apb(0, `CCA_OFS_CTRL, 0);
        check(q, 32'h44);
        check({moduleIoOe[2], moduleIoOut[2]}, 32'h3);
        pulse();
        pulse();
        check(wdCount, 0);
    endtask : t_match
    // Pulse width output and duty reload at wrap
    task automatic t_pwm();
        apb(1, modeAdr(3), 32'h42);
        apb(1, capAdr(3), 32'h4000);
        apb(1, `CCA_OFS_COUNT, 32'hFE);
        pulse();
        check({moduleIoOe[3], moduleIoOut[3]}, 32'h3);
        pulse();
        check({moduleIoOe[3], moduleIoOut[3]}, 32'h2);
    endtask : t_pwm
    // Module 4 watchdog match
    task automatic t_watchdog();
        apb(1, `CCA_OFS_COUNT, 32'h12);
        apb(1, `CCA_OFS_MODE, 32'h44);
        pulse();
        pulse();
        check(wdCount, 1);
    endtask : t_watchdog

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        {rst_n, psel, penable, pwrite, cpuIdle, timer0Overflow, extRun} = '0;
        {paddr, pwdata, portDataOut, portDriveEn, levelCmd} = '0;
        {nErrors, numChecks, wdCount} = '0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_sources();
        t_overflow();
        t_idle();
        t_capture();
        t_match();
        t_pwm();
        t_watchdog();
        complete_run();
    end
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge mclk);
        nErrors++;
        complete_run();
    end
endmodule : cca_top_tb_top
